// File: core/ppo_pkg.sv
//--------------------------------------------------------------------------
// Function
// - Line 3 drives timer compare B when enabled; pin-change input only if compare off.
// - Line 2 value: zero in two-wire output, else inverted compare B when enabled.
// - Two-wire mode forces pull-up off and steers direction of lines 2 and 0.
// - Line 2 input enabled by start interrupt, or pin change with no alternate use.
// - Line 1 value: serial data-out in three-wire mode, else compare A output when enabled.
// - Line 1 pin-change input only when three-wire mode and compare A are off.
// - Line 0 value: zero in two-wire output, else inverted compare A when enabled.
// - Line 0 input enabled by start interrupt, or pin change with no alternate use.
// - Group-0 pin change needs global flag, group-0 mask bit, alternate function off.
// - Group-1 pin change needs global flag, group-1 mask bit, alternate function off.
// - External level interrupt enabled only with global flag and its mask bit.
// - Serial start interrupt enabled only with global flag and start-detect enable bit.
// - Reset-pin disable fuse is active low for pull-up and direction of line 7.
// - Lines 4 and 5 I/O enables come from clock fuses, not registers.
// - Port A output latch, read/write at 0x1B, reset to zero.
// - Port A direction, read/write at 0x1A, set bit means output, reset zero.
// - Port A pin state, read-only at 0x19, sampled pin levels.
// - Port B output latch, read/write at 0x18, reset to zero.
// - Port B direction, read/write at 0x17, one bit per line.
// - Three-wire data-out replaces line 1 value; latch still drives pull-up as input.
// - Port B lines keep input enabled in sleep while pin change is enabled and the line has no alternate use.
//--------------------------------------------------------------------------
package ppo_pkg;

   localparam int          LINES              = 8;
   localparam int          AW                 = 8;

   // I/O locations
   localparam logic [7:0]  ADDR_PORT_B_DIR    = 8'h17;
   localparam logic [7:0]  ADDR_PORT_B_LATCH  = 8'h18;
   localparam logic [7:0]  ADDR_PORT_A_PIN    = 8'h19;
   localparam logic [7:0]  ADDR_PORT_A_DIR    = 8'h1A;
   localparam logic [7:0]  ADDR_PORT_A_LATCH  = 8'h1B;
   localparam logic [7:0]  ADDR_SERIAL_CTRL   = 8'h0D;
   localparam logic [7:0]  ADDR_GEN_IRQ_MASK  = 8'h3B;

   // Field positions
   localparam int          EXT_IRQ0_BIT       = 6;
   localparam int          PCG1_MASK_BIT      = 5;
   localparam int          PCG0_MASK_BIT      = 4;
   localparam int          START_IE_BIT       = 7;
   localparam logic [7:0]  GEN_IRQ_MASK_BITS  = 8'h70;

   // Reset values
   localparam logic [7:0]  REG_RESET          = 8'h00;

   // Clock-select fuse codes
   localparam logic [3:0]  CLOCK_SELECT_FUSES_EXT_CLOCK    = 4'h0;
   localparam logic [3:0]  CLOCK_SELECT_FUSES_RC_LOW       = 4'h1;
   localparam logic [3:0]  CLOCK_SELECT_FUSES_RC_HIGH      = 4'h4;

endpackage

// File: core/ppo_ovr_if.sv
`timescale 1ns/1ps
interface ppo_ovr_if;
   logic [7:0] pullup_override_enable;
   logic [7:0] pullup_override_value;
   logic [7:0] direction_override_enable;
   logic [7:0] direction_override_value;
   logic [7:0] pin_value_override_enable;
   logic [7:0] pin_value_override_value;
   logic [7:0] input_enable_override_enable;
   logic [7:0] input_enable_override_value;
   logic [7:0] latch;
   logic [7:0] dir;
   logic       sleep;
   logic [7:0] out_val;
   logic [7:0] oe_n;
   logic [7:0] pull_en;
   logic [7:0] in_en;

   modport src
   (
      output pullup_override_enable, pullup_override_value, direction_override_enable,
             direction_override_value, pin_value_override_enable, pin_value_override_value,
             input_enable_override_enable, input_enable_override_value, latch, dir, sleep,
      input  out_val, oe_n, pull_en, in_en
   );

   modport mux
   (
      input  pullup_override_enable, pullup_override_value, direction_override_enable,
             direction_override_value, pin_value_override_enable, pin_value_override_value,
             input_enable_override_enable, input_enable_override_value, latch, dir, sleep,
      output out_val, oe_n, pull_en, in_en
   );
endinterface

// File: core/ppo_pin_mux.sv
`timescale 1ns/1ps
module ppo_pin_mux
(
   ppo_ovr_if.mux ovr
);
   genvar i;

   generate
      for (i = 0; i < ppo_pkg::LINES; i++)
      begin : g_line
         logic dir_eff;
         // Override wins over the register-derived attribute
         assign dir_eff = ovr.direction_override_enable[i] ? ovr.direction_override_value[i]
                                                           : ovr.dir[i];
         assign ovr.oe_n[i]    = ~dir_eff;
         assign ovr.out_val[i] = ovr.pin_value_override_enable[i] ? ovr.pin_value_override_value[i]
                                                                  : ovr.latch[i];
         // Latch keeps the pull-up of an input even when the value is overridden
         assign ovr.pull_en[i] = ovr.pullup_override_enable[i] ? ovr.pullup_override_value[i]
                                                               : (ovr.latch[i] & ~dir_eff);
         // Inputs shut off in sleep unless an override keeps them alive
         assign ovr.in_en[i]   = ovr.input_enable_override_enable[i] ? ovr.input_enable_override_value[i]
                                                                     : ~ovr.sleep;
      end
   endgenerate
endmodule

// File: core/ppo_port_ctrl.sv
`timescale 1ns/1ps
module ppo_port_ctrl
(
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // Register port
   input  wire logic [7:0] bus_addr,
   input  wire logic [7:0] bus_wr_data,
   input  wire logic       bus_wr,
   input  wire logic       bus_rd,
   output logic      [7:0] bus_rd_data,
   // Core and peripheral status, same clock
   input  wire logic       global_irq_flag,
   input  wire logic       sleep_mode,
   input  wire logic       serial_twowire_mode_active,
   input  wire logic       serial_threewire_mode_active,
   input  wire logic       serial_clock_stretch_hold,
   input  wire logic       serial_twowire_data,
   input  wire logic       serial_data_out,
   input  wire logic       timer1_cmp_a_out_enable,
   input  wire logic       timer1_cmp_b_out_enable,
   input  wire logic       timer1_cmp_a_out,
   input  wire logic       timer1_cmp_b_out,
   input  wire logic       timer0_ext_clock,
   // Fuses
   input  wire logic       reset_pin_disable_fuse,
   input  wire logic       pll_clock_fuse,
   input  wire logic [3:0] clock_select_fuses,
   // Pins
   input  wire logic [7:0] port_a_pin_in,
   input  wire logic [7:0] port_b_pin_in,
   output logic      [7:0] port_a_out,
   output logic      [7:0] port_a_oe_n,
   output logic      [7:0] port_a_pullup,
   output logic      [7:0] port_a_in_en,
   output logic      [7:0] port_b_out,
   output logic      [7:0] port_b_oe_n,
   output logic      [7:0] port_b_pullup,
   output logic      [7:0] port_b_in_en,
   output logic      [7:0] port_b_level,
   // Qualified enables to the interrupt logic
   output logic            pinchg_group0_enable,
   output logic            pinchg_group1_enable,
   output logic            ext_irq0_enable,
   output logic            serial_start_irq_enable
);

   //-----------------------------------------------------------------------
   // Registers
   //-----------------------------------------------------------------------
   logic [7:0] port_a_output_latch_r;
   logic [7:0] port_a_direction_r;
   logic [7:0] port_b_output_latch_r;
   logic [7:0] port_b_direction_r;
   logic [7:0] general_irq_mask_reg_r;
   logic [7:0] serial_iface_control_reg_r;
   logic [7:0] pa_meta_r;
   logic [7:0] pa_sync_r;
   logic [7:0] pb_meta_r;
   logic [7:0] pb_sync_r;
   logic [7:0] rd_nxt;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] loc);
      hit = (a == loc);
   endfunction

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         port_a_output_latch_r <= ppo_pkg::REG_RESET;
         port_a_direction_r    <= ppo_pkg::REG_RESET;
      end
      else if (bus_wr)
      begin
         if (hit(bus_addr, ppo_pkg::ADDR_PORT_A_LATCH))
            port_a_output_latch_r <= bus_wr_data;
         if (hit(bus_addr, ppo_pkg::ADDR_PORT_A_DIR))
            port_a_direction_r <= bus_wr_data;
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         port_b_output_latch_r <= ppo_pkg::REG_RESET;
         port_b_direction_r    <= ppo_pkg::REG_RESET;
      end
      else if (bus_wr)
      begin
         if (hit(bus_addr, ppo_pkg::ADDR_PORT_B_LATCH))
            port_b_output_latch_r <= bus_wr_data;
         if (hit(bus_addr, ppo_pkg::ADDR_PORT_B_DIR))
            port_b_direction_r <= bus_wr_data;
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         general_irq_mask_reg_r     <= ppo_pkg::REG_RESET;
         serial_iface_control_reg_r <= ppo_pkg::REG_RESET;
      end
      else if (bus_wr)
      begin
         // Reserved mask bits stay zero
         if (hit(bus_addr, ppo_pkg::ADDR_GEN_IRQ_MASK))
            general_irq_mask_reg_r <= bus_wr_data & ppo_pkg::GEN_IRQ_MASK_BITS;
         if (hit(bus_addr, ppo_pkg::ADDR_SERIAL_CTRL))
            serial_iface_control_reg_r <= bus_wr_data;
      end
   end

   //-----------------------------------------------------------------------
   // Pin synchronisers
   //-----------------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         pa_meta_r <= ppo_pkg::REG_RESET;
         pa_sync_r <= ppo_pkg::REG_RESET;
         pb_meta_r <= ppo_pkg::REG_RESET;
         pb_sync_r <= ppo_pkg::REG_RESET;
      end
      else
      begin
         pa_meta_r <= port_a_pin_in;
         pa_sync_r <= pa_meta_r;
         pb_meta_r <= port_b_pin_in;
         pb_sync_r <= pb_meta_r;
      end
   end

   //-----------------------------------------------------------------------
   // Read port
   //-----------------------------------------------------------------------
   always_comb
   begin
      rd_nxt = 8'h00;
      if (bus_rd)
      begin
         unique case (bus_addr)
            ppo_pkg::ADDR_PORT_A_LATCH: rd_nxt = port_a_output_latch_r;
            ppo_pkg::ADDR_PORT_A_DIR:   rd_nxt = port_a_direction_r;
            ppo_pkg::ADDR_PORT_A_PIN:   rd_nxt = pa_sync_r;
            ppo_pkg::ADDR_PORT_B_LATCH: rd_nxt = port_b_output_latch_r;
            ppo_pkg::ADDR_PORT_B_DIR:   rd_nxt = port_b_direction_r;
            ppo_pkg::ADDR_GEN_IRQ_MASK: rd_nxt = general_irq_mask_reg_r;
            ppo_pkg::ADDR_SERIAL_CTRL:  rd_nxt = serial_iface_control_reg_r;
            default:                    rd_nxt = 8'h00;
         endcase
      end
   end

   // Data stand only in the cycle after the strobe
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         bus_rd_data <= 8'h00;
      else
         bus_rd_data <= rd_nxt;
   end

   //-----------------------------------------------------------------------
   // Qualified enables
   //-----------------------------------------------------------------------
   logic pcg0_en;
   logic pcg1_en;
   logic ext_irq0_enable_en;
   logic start_en;
   logic io4_en;
   logic io5_en;
   logic ext_clk_en;
   logic rst_fn;
   logic tw;
   logic thw;

   // Alternate-function masking is applied per line below
   assign pcg0_en  = global_irq_flag & general_irq_mask_reg_r[ppo_pkg::PCG0_MASK_BIT];
   assign pcg1_en  = global_irq_flag & general_irq_mask_reg_r[ppo_pkg::PCG1_MASK_BIT];
   assign ext_irq0_enable_en  = global_irq_flag & general_irq_mask_reg_r[ppo_pkg::EXT_IRQ0_BIT];
   assign start_en = global_irq_flag & serial_iface_control_reg_r[ppo_pkg::START_IE_BIT];
   assign tw       = serial_twowire_mode_active;
   assign thw      = serial_threewire_mode_active;

   // Fuse reads 1 when unprogrammed, so 1 keeps the reset function
   assign rst_fn     = reset_pin_disable_fuse;
   // Line 4 is free only with the internal RC and no PLL; line 5 also with the external clock
   assign ext_clk_en = pll_clock_fuse & (clock_select_fuses == ppo_pkg::CLOCK_SELECT_FUSES_EXT_CLOCK);
   assign io5_en     = pll_clock_fuse & (ext_clk_en | ((clock_select_fuses >= ppo_pkg::CLOCK_SELECT_FUSES_RC_LOW)
                       & (clock_select_fuses <= ppo_pkg::CLOCK_SELECT_FUSES_RC_HIGH)));
   assign io4_en     = io5_en & ~ext_clk_en;

   //-----------------------------------------------------------------------
   // Override tables
   //-----------------------------------------------------------------------
   ppo_ovr_if pb_ovr ();

   assign pb_ovr.latch = port_b_output_latch_r;
   assign pb_ovr.dir   = port_b_direction_r;
   assign pb_ovr.sleep = sleep_mode;

   // Pull-up: two-wire lines are released, reset line pulled up, oscillator lines off
   assign pb_ovr.pullup_override_enable = {rst_fn, 1'b0, ~io5_en, ~io4_en, 1'b0, tw, 1'b0, tw};
   assign pb_ovr.pullup_override_value  = {1'b1, 7'h00};

   // Direction: open-collector drive in two-wire mode
   assign pb_ovr.direction_override_enable = {rst_fn, 1'b0, ~io5_en, ~io4_en, 1'b0, tw, 1'b0, tw};
   assign pb_ovr.direction_override_value  =
      {4'h0, 1'b0,
       (serial_clock_stretch_hold | ~port_b_output_latch_r[2]) & port_b_direction_r[2],
       1'b0,
       (~serial_twowire_data | ~port_b_output_latch_r[0]) & port_b_direction_r[0]};

   // Pin value
   assign pb_ovr.pin_value_override_enable =
      {4'h0,
       timer1_cmp_b_out_enable,
       (tw & port_b_direction_r[2]) | timer1_cmp_b_out_enable,
       thw | timer1_cmp_a_out_enable,
       (tw & port_b_direction_r[0]) | timer1_cmp_a_out_enable};
   assign pb_ovr.pin_value_override_value =
      {4'h0,
       timer1_cmp_b_out,
       ~(tw & port_b_direction_r[2]) & timer1_cmp_b_out_enable & ~timer1_cmp_b_out,
       thw ? serial_data_out : (timer1_cmp_a_out_enable & timer1_cmp_a_out),
       ~(tw & port_b_direction_r[0]) & timer1_cmp_a_out_enable & ~timer1_cmp_a_out};

   // Digital input: held on in sleep while pin change stays unmasked and the line has no alternate use
   assign pb_ovr.input_enable_override_enable =
      {pcg1_en | rst_fn,
       (~timer0_ext_clock & pcg1_en) | ext_irq0_enable_en,
       pcg1_en | ~io5_en,
       pcg1_en | ~io4_en | ext_clk_en,
       pcg0_en & ~timer1_cmp_b_out_enable,
       (~(tw | thw | timer1_cmp_b_out_enable) & pcg0_en) | start_en,
       ~(thw | timer1_cmp_a_out_enable) & pcg0_en,
       (~(tw | thw | timer1_cmp_a_out_enable) & pcg0_en) | start_en};
   assign pb_ovr.input_enable_override_value =
      {pcg1_en & ~rst_fn,
       1'b1,
       pcg1_en & io5_en,
       (pcg1_en & io4_en) | ext_clk_en,
       4'hF};

   ppo_pin_mux u_pb_mux
   (
      .ovr (pb_ovr)
   );

   //-----------------------------------------------------------------------
   // Registered pin outputs
   //-----------------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         port_a_out    <= 8'h00;
         port_a_oe_n   <= 8'hFF;
         port_a_pullup <= 8'h00;
         port_a_in_en  <= 8'h00;
      end
      else
      begin
         port_a_out    <= port_a_output_latch_r;
         port_a_oe_n   <= ~port_a_direction_r;
         port_a_pullup <= port_a_output_latch_r & ~port_a_direction_r;
         port_a_in_en  <= {8{~sleep_mode}};
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         port_b_out    <= 8'h00;
         port_b_oe_n   <= 8'hFF;
         port_b_pullup <= 8'h00;
         port_b_in_en  <= 8'h00;
         port_b_level  <= 8'h00;
      end
      else
      begin
         port_b_out    <= pb_ovr.out_val;
         port_b_oe_n   <= pb_ovr.oe_n;
         port_b_pullup <= pb_ovr.pull_en;
         port_b_in_en  <= pb_ovr.in_en;
         // Disabled inputs read low so floating pins cannot toggle peripherals
         port_b_level  <= pb_sync_r & pb_ovr.in_en;
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         pinchg_group0_enable    <= 1'b0;
         pinchg_group1_enable    <= 1'b0;
         ext_irq0_enable         <= 1'b0;
         serial_start_irq_enable <= 1'b0;
      end
      else
      begin
         pinchg_group0_enable    <= pcg0_en;
         pinchg_group1_enable    <= pcg1_en;
         ext_irq0_enable         <= ext_irq0_enable_en;
         serial_start_irq_enable <= start_en;
      end
   end

   //-----------------------------------------------------------------------
   // Assertions
   //-----------------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_line3_cmp_drive: assert property (timer1_cmp_b_out_enable |=> port_b_out[3] == $past(timer1_cmp_b_out))
      else $error("line 3 does not follow compare B");
   a_line3_input_keep: assert property ((pcg0_en && !timer1_cmp_b_out_enable && sleep_mode) |=> port_b_in_en[3])
      else $error("line 3 input lost in sleep");
   a_line2_twowire_zero: assert property ((tw && port_b_direction_r[2]) |=> !port_b_out[2])
      else $error("line 2 not driven low in two-wire mode");
   a_line2_scl_pull: assert property ((tw && port_b_direction_r[2] && !port_b_output_latch_r[2])
                                      |=> (!port_b_oe_n[2] && !port_b_pullup[2]))
      else $error("line 2 clock not pulled low");
   a_line0_sda_release: assert property ((tw && !port_b_direction_r[0]) |=> (port_b_oe_n[0] && !port_b_pullup[0]))
      else $error("line 0 not released in two-wire mode");
   a_start_input_on: assert property ((start_en && sleep_mode) |=> (port_b_in_en[0] && port_b_in_en[2]))
      else $error("start detect input disabled");
   a_line1_data_out: assert property (thw |=> port_b_out[1] == $past(serial_data_out))
      else $error("line 1 does not carry serial data out");
   a_line1_input_off: assert property ((thw && sleep_mode) |=> !port_b_in_en[1])
      else $error("line 1 input kept in three-wire sleep");
   a_line1_pullup_kept: assert property ((thw && !port_b_direction_r[1] && port_b_output_latch_r[1])
                                         |=> port_b_pullup[1])
      else $error("line 1 pull-up lost in three-wire mode");
   a_line0_cmp_inv: assert property ((timer1_cmp_a_out_enable && !tw) |=> port_b_out[0] == !$past(timer1_cmp_a_out))
      else $error("line 0 not inverted compare A");
   a_group0_gate: assert property (pinchg_group0_enable |-> $past(global_irq_flag))
      else $error("group 0 enabled without global flag");
   a_group1_gate: assert property (pinchg_group1_enable |-> $past(general_irq_mask_reg_r[ppo_pkg::PCG1_MASK_BIT]))
      else $error("group 1 enabled without mask bit");
   a_ext_irq_gate: assert property (ext_irq0_enable
                                    |-> ($past(global_irq_flag) && $past(general_irq_mask_reg_r[ppo_pkg::EXT_IRQ0_BIT])))
      else $error("external interrupt enable not gated");
   // Release edge still sees reset values, so skip the attempt started there
   a_reset_line_hold: assert property ((!rst && reset_pin_disable_fuse)
                                       |=> (port_b_pullup[7] && port_b_oe_n[7]))
      else $error("reset line not held as pulled-up input");
   a_latch_readback: assert property ((bus_rd && bus_addr == ppo_pkg::ADDR_PORT_A_LATCH)
                                      |=> bus_rd_data == $past(port_a_output_latch_r))
      else $error("port A latch read back wrong");

   c_twowire_out: cover property (tw && port_b_direction_r[2] && port_b_direction_r[0]);
   c_threewire:   cover property (thw && port_b_direction_r[1]);
   c_cmp_b_pin:   cover property (timer1_cmp_b_out_enable ##1 !timer1_cmp_b_out_enable);
   c_start_sleep: cover property (start_en && sleep_mode);

endmodule

// File: bench/ppo_pin_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Pin pads seen from outside the device
// ----------------------------------------
module ppo_pin_model
(
   input  wire logic       clk_sys,
   input  wire logic [7:0] drv,
   input  wire logic [7:0] oe_n,
   input  wire logic [7:0] pull_en,
   output logic      [7:0] pin
);
   initial pin = 8'h00;
   // Undriven, unpulled lines wander, so a stale value never looks valid
   always @(posedge clk_sys)
      for (int i = 0; i < 8; i++)
         pin[i] <= (oe_n[i] === 1'b0) ? drv[i] : ((pull_en[i] === 1'b1) ? 1'b1 : ~pin[i]);
endmodule

// File: bench/port_pin_override_logic_tb_top.sv
`timescale 1ns/1ps
module port_pin_override_logic_tb_top;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [7:0] bus_addr = 8'h00, bus_wr_data = 8'h00, bus_rd_data;
   logic bus_wr = 1'b0, bus_rd = 1'b0, rd_d = 1'b0, gi = 1'b0, slp = 1'b0;
   logic [8:0] st_v = 9'h000;
   logic rf = 1'b1, pll = 1'b1;
   logic [3:0] cks = 4'h0;
   logic [7:0] pa_ie, pb_lv;
   logic [7:0] pa_o, pa_oe, pa_pu, pa_pin, pb_o, pb_oe, pb_pu, pb_ie, pb_pin;
   logic g0, g1, ext0, sstart;
   logic [7:0] q[$];
   logic [7:0] d;
   int err_total = 0, total_checks = 0, seed = 32'h13f1;
   always #5 clk_sys = ~clk_sys;
   ppo_pin_model pa_m (.clk_sys(clk_sys), .drv(pa_o), .oe_n(pa_oe), .pull_en(pa_pu), .pin(pa_pin));
   ppo_pin_model pb_m (.clk_sys(clk_sys), .drv(pb_o), .oe_n(pb_oe), .pull_en(pb_pu), .pin(pb_pin));
   ppo_port_ctrl DUT (.clk_sys(clk_sys), .rst(rst), .bus_addr(bus_addr), .bus_wr_data(bus_wr_data),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rd_data(bus_rd_data), .global_irq_flag(gi), .sleep_mode(slp),
      .serial_twowire_mode_active(st_v[8]), .serial_threewire_mode_active(st_v[7]),
      .serial_clock_stretch_hold(st_v[6]), .serial_twowire_data(st_v[5]), .serial_data_out(st_v[4]),
      .timer1_cmp_a_out_enable(st_v[3]), .timer1_cmp_b_out_enable(st_v[2]), .timer1_cmp_a_out(st_v[1]),
      .timer1_cmp_b_out(st_v[0]), .timer0_ext_clock(1'b0), .reset_pin_disable_fuse(rf),
      .pll_clock_fuse(pll), .clock_select_fuses(cks), .port_a_pin_in(pa_pin), .port_b_pin_in(pb_pin),
      .port_a_out(pa_o), .port_a_oe_n(pa_oe), .port_a_pullup(pa_pu), .port_a_in_en(pa_ie),
      .port_b_out(pb_o), .port_b_oe_n(pb_oe), .port_b_pullup(pb_pu), .port_b_in_en(pb_ie),
      .port_b_level(pb_lv), .pinchg_group0_enable(g0), .pinchg_group1_enable(g1),
      .ext_irq0_enable(ext0), .serial_start_irq_enable(sstart));

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e)
      begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      bus_addr <= a;
      bus_wr_data <= v;
      bus_wr <= 1'b1;
      @(posedge clk_sys);
      bus_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      bus_addr <= a;
      bus_rd <= 1'b1;
      q.push_back(e);
      @(posedge clk_sys);
      bus_rd <= 1'b0;
   endtask
   task automatic drive(input logic [8:0] v, input logic g, input logic s);
      @(posedge clk_sys);
      st_v <= v;
      gi <= g;
      slp <= s;
      repeat (4) @(posedge clk_sys);
      #1;
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // --------------------------------------------
   // Read data stands only in the cycle after the strobe
   // --------------------------------------------
   always @(posedge clk_sys) rd_d <= bus_rd;
   always @(negedge clk_sys)
      if (rd_d)
         chk("rd_data", q.pop_front(), bus_rd_data);

   initial
   begin
      repeat (20000) @(posedge clk_sys);
      err_total++;
      conclude();
   end

   initial
   begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      d = 8'($random(seed));
      q.delete();
      for (int a = 8'h17; a <= 8'h1B; a++)
         if (a != 8'h19)
            rd(a[7:0], 8'h00);
      for (int a = 8'h17; a <= 8'h1B; a++)
         if (a != 8'h19)
         begin
            wr(a[7:0], d ^ a[7:0]);
            rd(a[7:0], d ^ a[7:0]);
         end
      rd(8'h20, 8'h00);
      $display("test registers done");
      wr(8'h1A, 8'hFF);
      wr(8'h1B, d);
      wr(8'h19, ~d);
      drive(9'h000, 1'b0, 1'b0);
      rd(8'h19, d);
      $display("test pin state done");
      wr(8'h17, 8'h05);
      wr(8'h18, 8'h00);
      drive(9'h100, 1'b0, 1'b0);
      chk("b_out2", 8'h00, {7'h00, pb_o[2]});
      chk("b_oe_n2_0", 8'h00, {6'h00, pb_oe[2], pb_oe[0]});
      chk("b_pu2_0", 8'h00, {6'h00, pb_pu[2], pb_pu[0]});
      chk("b_out0", 8'h00, {7'h00, pb_o[0]});
      $display("test two-wire done");
      wr(8'h17, 8'h0F);
      for (int v = 0; v < 2; v++)
      begin
         drive({1'b0, 1'b1, 2'b00, v[0], 4'h0}, 1'b0, 1'b0);
         chk("b_out1", {7'h00, v[0]}, {7'h00, pb_o[1]});
      end
      for (int v = 0; v < 2; v++)
      begin
         drive({5'h00, 2'b11, v[0], ~v[0]}, 1'b0, 1'b0);
         chk("b_out3", {7'h00, ~v[0]}, {7'h00, pb_o[3]});
         chk("b_out2", {7'h00, v[0]}, {7'h00, pb_o[2]});
         chk("b_out1", {7'h00, v[0]}, {7'h00, pb_o[1]});
         chk("b_out0", {7'h00, ~v[0]}, {7'h00, pb_o[0]});
      end
      // Levels come back through the pads and two sync stages
      repeat (2) @(posedge clk_sys);
      #1;
      chk("b_level3_0", 8'h06, {4'h0, pb_lv[3:0]});
      $display("test compare outputs done");
      wr(8'h3B, 8'h70);
      wr(8'h0D, 8'h80);
      rd(8'h3B, 8'h70);
      drive(9'h000, 1'b1, 1'b1);
      chk("ext0", 8'h01, {7'h00, ext0});
      chk("sstart", 8'h01, {7'h00, sstart});
      chk("group0", 8'h01, {7'h00, g0});
      chk("group1", 8'h01, {7'h00, g1});
      chk("b_in_en3_0", 8'h0F, {4'h0, pb_ie[3:0]});
      chk("a_in_en", 8'h00, pa_ie);
      drive(9'h00C, 1'b1, 1'b1);
      chk("b_in_en3_1", 8'h02, {5'h00, pb_ie[3:1]});
      chk("b_in_en0", 8'h01, {7'h00, pb_ie[0]});
      drive(9'h000, 1'b0, 1'b0);
      chk("ext0", 8'h00, {7'h00, ext0});
      chk("sstart", 8'h00, {7'h00, sstart});
      chk("group0", 8'h00, {7'h00, g0});
      chk("a_in_en", 8'hFF, pa_ie);
      $display("test enables done");
      wr(8'h17, 8'h30);
      drive(9'h000, 1'b0, 1'b0);
      chk("b_oe_n7_4", 8'h0D, {4'h0, pb_oe[7:4]});
      chk("b_pu7", 8'h01, {7'h00, pb_pu[7]});
      @(posedge clk_sys);
      rf <= 1'b0;
      cks <= 4'h2;
      drive(9'h000, 1'b0, 1'b0);
      chk("b_oe_n7_4", 8'h0C, {4'h0, pb_oe[7:4]});
      chk("b_pu7", 8'h00, {7'h00, pb_pu[7]});
      @(posedge clk_sys);
      pll <= 1'b0;
      drive(9'h000, 1'b0, 1'b0);
      chk("b_oe_n7_4", 8'h0F, {4'h0, pb_oe[7:4]});
      $display("test fuses done");
      repeat (3) @(posedge clk_sys);
      conclude();
   end
endmodule
